// ==== rtl/lcd_scan_map.svh ====
// constants and register map of the lcd common scan link
// Notes on behaviour
// - marker shifts on line clock falling edge
// - alternation pin output internally, input externally
// - five-bit select gives lines per half-period
// - board selects 2 to 31 lines, never 1
// - board should prefer 10 to 31 lines
// - select zero means external alternation input
// - count selects give 240, 200 or 160 outputs
// - direction high: first pin out, second in
// - pump clock tied to line clock, else low
// - pump enable high runs pump, low stops
// - generator reset low clears alternation and counter in internal mode only
// - scan register is 240 bits, bidirectional
// - marker enters lowest active stage when direction high
// - output level from scan bit and alternation
`ifndef LCD_SCAN_MAP_SVH
`define LCD_SCAN_MAP_SVH

// ****************************************
// scan geometry
// ****************************************
`define SCAN_STAGES 240
`define SCAN_TRIM_MID 20
`define SCAN_TRIM_NARROW 40
`define ALT_SEL_W 5

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 8
`define LINE_HALF_NS 400
`define LINE_HALF_CYC (`LINE_HALF_NS / `CLK_PERIOD_NS)

// ****************************************
// controller registers
// ****************************************
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_STATUS 8'h08
`define CTRL_RUN 0
`define CTRL_PUMP 1
`define CTRL_DIR 2
`define CTRL_EXT_ALT 3
`define CTRL_GEN_RST 4
`define CTRL_MASK 32'h0000_001F
`define CTRL_RESET 32'h0000_0004
`define CFG_PERIOD_LSB 0
`define CFG_SEL_A 5
`define CFG_SEL_B 6
`define CFG_LINES_LSB 8
`define CFG_MASK 32'h0000_FF7F
`define CFG_RESET 32'h0000_F06A
`define STAT_RUNNING 16
`define STAT_RETURN 17
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/lcd_scan_pkg.sv ====
// shared types of the lcd common scan link
package lcd_scan_pkg;

  typedef enum logic [1:0] {
    LVL_MID = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_LOW = 2'h2
  } drive_level_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_HIGH = 3'h2,
    ST_LOW = 3'h4
  } line_phase_t;

endpackage

// ==== rtl/lcd_scan_if.sv ====
// pin-level link between display controller and common driver
`include "lcd_scan_map.svh"

interface lcd_scan_if;
  logic line_shift_clock;
  logic pump_clock_in;
  logic pump_enable;
  logic [`ALT_SEL_W-1:0] alternation_period;
  logic output_count_select_a;
  logic output_count_select_b;
  logic shift_direction_select;
  logic generator_reset_n;
  // two-way pins: per-end drive and enable, resolved level
  logic first_dev_o;
  logic first_dev_oe;
  logic first_host_o;
  logic first_host_oe;
  logic marker_pin_first;
  logic second_dev_o;
  logic second_dev_oe;
  logic second_host_o;
  logic second_host_oe;
  logic marker_pin_second;
  logic alt_dev_o;
  logic alt_dev_oe;
  logic alt_host_o;
  logic alt_host_oe;
  logic alternation_pin;

  // undriven pin reads low, like a weak pull-down
  assign marker_pin_first = first_dev_oe ? first_dev_o :
                            (first_host_oe & first_host_o);
  assign marker_pin_second = second_dev_oe ? second_dev_o :
                             (second_host_oe & second_host_o);
  assign alternation_pin = alt_dev_oe ? alt_dev_o :
                           (alt_host_oe & alt_host_o);

  modport device (
    input line_shift_clock, pump_clock_in, pump_enable,
    input alternation_period, output_count_select_a,
    input output_count_select_b, shift_direction_select,
    input generator_reset_n, marker_pin_first, marker_pin_second,
    input alternation_pin,
    output first_dev_o, first_dev_oe, second_dev_o, second_dev_oe,
    output alt_dev_o, alt_dev_oe
  );

  modport host (
    output line_shift_clock, pump_clock_in, pump_enable,
    output alternation_period, output_count_select_a,
    output output_count_select_b, shift_direction_select,
    output generator_reset_n,
    output first_host_o, first_host_oe, second_host_o, second_host_oe,
    output alt_host_o, alt_host_oe,
    input marker_pin_first, marker_pin_second, alternation_pin
  );
endinterface

// ==== rtl/pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // asynchronous pins
  input wire logic [WIDTH-1:0] i_pins,
  // filtered levels
  output logic [WIDTH-1:0] o_level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync: WIDTH must be at least 1");
  end

  always_comb begin
    state_d = state_q;
    state_d.s1 = i_pins;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    // a level counts only once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (state_q.s2[i] == state_q.s3[i]) begin
        state_d.level[i] = state_q.s3[i];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_level = state_q.level;
endmodule // pin_sync

// ==== rtl/lcd_scan_device.sv ====
// common driver end: scan register, alternation generator, pump control
`include "lcd_scan_map.svh"

module lcd_scan_device
  import lcd_scan_pkg::*;
#(
  parameter int STAGES = `SCAN_STAGES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // link to the display controller
  lcd_scan_if.device link,
  // drive level per common output
  output logic [STAGES-1:0][1:0] o_common_level,
  // status
  output logic o_alternation,
  output logic o_alt_internal,
  output logic o_mode_valid,
  // charge pump
  output logic o_pump_on,
  output logic o_pump_drive
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (STAGES <= 2 * `SCAN_TRIM_NARROW) begin : g_stage_check
    $error("lcd_scan_device: STAGES too small for the narrow mode");
  end

  // ****************************************
  // types and state
  // ****************************************
  localparam int SYNC_W = 10 + `ALT_SEL_W;

  typedef struct packed {
    logic clk_seen;
    logic [STAGES-1:0] sr;
    logic [`ALT_SEL_W-1:0] line_cnt;
    logic alt;
    logic mark_out;
    logic pump_drive;
    logic [STAGES-1:0][1:0] level;
  } dev_state_t;

  dev_state_t state_q;
  dev_state_t state_d;

  // ****************************************
  // pin synchronisation
  // ****************************************
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic alt_pin_s;
  logic second_s;
  logic first_s;
  logic gen_rst_n_s;
  logic pump_clk_s;
  logic pump_en_s;
  logic shl_s;
  logic sel_b_s;
  logic sel_a_s;
  logic [`ALT_SEL_W-1:0] period_s;
  logic line_clk_s;
  logic mode_valid;
  logic internal;

  assign pins_raw = {
    link.line_shift_clock,
    link.alternation_period,
    link.output_count_select_a,
    link.output_count_select_b,
    link.shift_direction_select,
    link.pump_enable,
    link.pump_clock_in,
    link.generator_reset_n,
    link.marker_pin_first,
    link.marker_pin_second,
    link.alternation_pin
  };

  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_pins(pins_raw),
    .o_level(pins_s)
  );

  assign {line_clk_s, period_s, sel_a_s, sel_b_s, shl_s, pump_en_s,
    pump_clk_s, gen_rst_n_s, first_s, second_s, alt_pin_s} = pins_s;

  // both selects low is prohibited: no stage is active then
  assign mode_valid = sel_a_s | sel_b_s;
  assign internal = |period_s;

  // ****************************************
  // helpers
  // ****************************************
  // stages cut from each end of the register for the chosen mode
  function automatic int trim_of(input logic sel_a, input logic sel_b);
    if (sel_a == sel_b) begin
      return 0;
    end else if (sel_a) begin
      return `SCAN_TRIM_MID;
    end else begin
      return `SCAN_TRIM_NARROW;
    end
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    int lo;
    int hi;
    int src;
    int out_idx;
    logic fall;
    logic in_bit;
    lo = trim_of(sel_a_s, sel_b_s);
    hi = STAGES - 1 - lo;
    src = 0;
    out_idx = 0;
    fall = state_q.clk_seen & ~line_clk_s;
    in_bit = shl_s ? second_s : first_s;
    state_d = state_q;
    state_d.clk_seen = line_clk_s;

    // scan register
    for (int i = 0; i < STAGES; i++) begin
      if (!mode_valid || i < lo || i > hi) begin
        // inactive stages hold zero and are skipped by the marker
        state_d.sr[i] = 1'b0;
      end else if (fall) begin
        if (shl_s) begin
          src = (i == lo) ? i : i - 1;
          state_d.sr[i] = (i == lo) ? in_bit : state_q.sr[src];
        end else begin
          src = (i == hi) ? i : i + 1;
          state_d.sr[i] = (i == hi) ? in_bit : state_q.sr[src];
        end
      end
    end

    // serial output taken from the far active stage
    out_idx = shl_s ? hi : lo;
    state_d.mark_out = mode_valid & state_d.sr[out_idx];

    // alternation generator
    if (!internal) begin
      state_d.line_cnt = '0;
      state_d.alt = alt_pin_s;
    end else if (!gen_rst_n_s) begin
      state_d.line_cnt = '0;
      state_d.alt = 1'b0;
    end else if (fall) begin
      // a select of one is illegal; it toggles every line here
      if (`ALT_SEL_W'(state_q.line_cnt + 1'b1) >= period_s) begin
        state_d.line_cnt = '0;
        state_d.alt = ~state_q.alt;
      end else begin
        state_d.line_cnt = `ALT_SEL_W'(state_q.line_cnt + 1'b1);
      end
    end

    // drive level of every common output
    for (int i = 0; i < STAGES; i++) begin
      if (state_d.sr[i]) begin
        state_d.level[i] = state_d.alt ? LVL_HIGH : LVL_LOW;
      end else begin
        state_d.level[i] = LVL_MID;
      end
    end

    // pump runs only while enabled, clocked from its own pin
    state_d.pump_drive = pump_en_s & pump_clk_s;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // pins and outputs
  // ****************************************
  // marker enables held off while the mode is invalid, so reset never fights
  assign link.first_dev_o = state_q.mark_out;
  assign link.first_dev_oe = mode_valid & shl_s;
  assign link.second_dev_o = state_q.mark_out;
  assign link.second_dev_oe = mode_valid & ~shl_s;
  assign link.alt_dev_o = state_q.alt;
  assign link.alt_dev_oe = internal;

  assign o_common_level = state_q.level;
  assign o_alternation = state_q.alt;
  assign o_alt_internal = internal;
  assign o_mode_valid = mode_valid;
  assign o_pump_on = pump_en_s;
  assign o_pump_drive = state_q.pump_drive;

endmodule // lcd_scan_device

// ==== rtl/lcd_scan_host.sv ====
// controller end: axi4-lite registers, line clock and marker generation
`include "lcd_scan_map.svh"

module lcd_scan_host
  import lcd_scan_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int LINE_HALF = `LINE_HALF_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // link to the common driver
  lcd_scan_if.host link,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  if (ADDR_W < 4 || ADDR_W > 8 || LINE_HALF < 1 || LINE_HALF > 65535)
  begin : g_param_check
    $error("lcd_scan_host: ADDR_W or LINE_HALF out of range");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [15:0] frames;
    line_phase_t phase;
    logic [15:0] div;
    logic [7:0] line_idx;
    logic line_clk;
    logic mark;
    logic pclk;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } host_state_t;

  host_state_t state_q;
  host_state_t state_d;
  logic [1:0] ret_s;
  logic ret;
  logic dir;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // returning marker
  // ****************************************
  pin_sync #(
    .WIDTH(2)
  ) u_ret_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_pins({link.marker_pin_first, link.marker_pin_second}),
    .o_level(ret_s)
  );

  assign dir = state_q.ctrl[`CTRL_DIR];
  assign ret = dir ? ret_s[1] : ret_s[0];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    // register bus: address and data taken in either order
    if (i_awvalid && !state_q.aw_have) begin
      state_d.aw_have = 1'b1;
      state_d.aw_addr = i_awaddr;
    end
    if (i_wvalid && !state_q.w_have) begin
      state_d.w_have = 1'b1;
      state_d.wdata = i_wdata;
      state_d.wstrb = i_wstrb;
    end
    if (state_q.bvalid && i_bready) begin
      state_d.bvalid = 1'b0;
    end
    if (state_q.aw_have && state_q.w_have && !state_q.bvalid) begin
      state_d.aw_have = 1'b0;
      state_d.w_have = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = `RESP_OKAY;
      if (state_q.aw_addr == ADDR_W'(`REG_CTRL)) begin
        state_d.ctrl = merge_bytes(state_q.ctrl, state_q.wdata,
                                   state_q.wstrb) & `CTRL_MASK;
      end else if (state_q.aw_addr == ADDR_W'(`REG_CFG)) begin
        state_d.cfg = merge_bytes(state_q.cfg, state_q.wdata,
                                  state_q.wstrb) & `CFG_MASK;
      end else if (state_q.aw_addr != ADDR_W'(`REG_STATUS)) begin
        state_d.bresp = `RESP_SLVERR;
      end
    end
    if (state_q.rvalid && i_rready) begin
      state_d.rvalid = 1'b0;
    end
    if (i_arvalid && !state_q.rvalid) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = `RESP_OKAY;
      if (i_araddr == ADDR_W'(`REG_CTRL)) begin
        state_d.rdata = state_q.ctrl;
      end else if (i_araddr == ADDR_W'(`REG_CFG)) begin
        state_d.rdata = state_q.cfg;
      end else if (i_araddr == ADDR_W'(`REG_STATUS)) begin
        state_d.rdata = {14'h0000, ret, state_q.phase != ST_IDLE,
                         state_q.frames};
      end else begin
        state_d.rdata = 32'h0000_0000;
        state_d.rresp = `RESP_SLVERR;
      end
    end

    // line clock: marker set with the rise into the high phase, stable over the fall
    case (state_q.phase)
      ST_IDLE: begin
        if (state_q.ctrl[`CTRL_RUN]) begin
          state_d.phase = ST_HIGH;
          state_d.div = '0;
          state_d.line_clk = 1'b1;
          state_d.mark = (state_q.line_idx == 8'h00);
        end
      end
      ST_HIGH: begin
        if (state_q.div == 16'(LINE_HALF - 1)) begin
          state_d.phase = ST_LOW;
          state_d.div = '0;
          state_d.line_clk = 1'b0;
          if (8'(state_q.line_idx + 1'b1) >=
              state_q.cfg[`CFG_LINES_LSB +: 8]) begin
            state_d.line_idx = 8'h00;
            state_d.frames = 16'(state_q.frames + 1'b1);
          end else begin
            state_d.line_idx = 8'(state_q.line_idx + 1'b1);
          end
        end else begin
          state_d.div = 16'(state_q.div + 1'b1);
        end
      end
      ST_LOW: begin
        if (state_q.div == 16'(LINE_HALF - 1)) begin
          state_d.div = '0;
          state_d.mark = 1'b0;
          if (state_q.ctrl[`CTRL_RUN]) begin
            state_d.phase = ST_HIGH;
            state_d.line_clk = 1'b1;
            state_d.mark = (state_q.line_idx == 8'h00);
          end else begin
            state_d.phase = ST_IDLE;
          end
        end else begin
          state_d.div = 16'(state_q.div + 1'b1);
        end
      end
      default: begin
        state_d.phase = ST_IDLE;
      end
    endcase
    // pump clock follows the line clock only while the pump is on
    state_d.pclk = state_d.ctrl[`CTRL_PUMP] & state_d.line_clk;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= '0;
      state_q.ctrl <= `CTRL_RESET;
      state_q.cfg <= `CFG_RESET;
      state_q.phase <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // pins and bus outputs
  // ****************************************
  assign link.line_shift_clock = state_q.line_clk;
  assign link.pump_clock_in = state_q.pclk;
  assign link.pump_enable = state_q.ctrl[`CTRL_PUMP];
  assign link.alternation_period = state_q.cfg[`CFG_PERIOD_LSB +:
                                               `ALT_SEL_W];
  assign link.output_count_select_a = state_q.cfg[`CFG_SEL_A];
  assign link.output_count_select_b = state_q.cfg[`CFG_SEL_B];
  assign link.shift_direction_select = dir;
  assign link.generator_reset_n = ~state_q.ctrl[`CTRL_GEN_RST];
  assign link.first_host_o = state_q.mark;
  assign link.first_host_oe = ~dir;
  assign link.second_host_o = state_q.mark;
  assign link.second_host_oe = dir;
  assign link.alt_host_o = state_q.ctrl[`CTRL_EXT_ALT];
  assign link.alt_host_oe = ~|link.alternation_period;

  assign o_awready = ~state_q.aw_have;
  assign o_wready = ~state_q.w_have;
  assign o_bresp = state_q.bresp;
  assign o_bvalid = state_q.bvalid;
  assign o_arready = ~state_q.rvalid;
  assign o_rdata = state_q.rdata;
  assign o_rresp = state_q.rresp;
  assign o_rvalid = state_q.rvalid;

endmodule // lcd_scan_host

// ==== verif/lcd_common_scan_control_monitor.sv ====
// pin assertions on the scan link between controller and common driver
`include "lcd_scan_map.svh"

module lcd_common_scan_control_monitor (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // controller pins
  input wire logic line_shift_clock,
  input wire logic pump_clock_in,
  input wire logic pump_enable,
  input wire logic [`ALT_SEL_W-1:0] alternation_period,
  input wire logic output_count_select_a,
  input wire logic output_count_select_b,
  input wire logic shift_direction_select,
  input wire logic generator_reset_n,
  // driver pins
  input wire logic first_dev_o,
  input wire logic first_dev_oe,
  input wire logic second_dev_o,
  input wire logic second_dev_oe,
  input wire logic alt_dev_o,
  input wire logic alt_dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  wire logic mode_ok = output_count_select_a | output_count_select_b;
  wire logic [8:0] cfg_pins = {output_count_select_a, output_count_select_b,
    shift_direction_select, generator_reset_n, alternation_period};
  logic [3:0] quiet_q;

  // ****************************************
  // cycles since the last line fall or pin change
  // ****************************************
  // driver sees pins through a filter, so allow a few cycles of lag
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      quiet_q <= 4'h0;
    end else if ($fell(line_shift_clock) || $changed(cfg_pins)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end

  sequence s_dir_high;
    (shift_direction_select && mode_ok) [*8];
  endsequence
  sequence s_dir_low;
    (!shift_direction_select && mode_ok) [*8];
  endsequence

  a_dir_high_roles: assert property (
      s_dir_high |-> first_dev_oe && !second_dev_oe)
    else $error("first pin not sole driver");
  a_dir_low_roles: assert property (
      s_dir_low |-> second_dev_oe && !first_dev_oe)
    else $error("second pin not sole driver");
  a_prohibited_quiet: assert property (
      (!mode_ok) [*8] |-> !first_dev_oe && !second_dev_oe)
    else $error("marker driven in prohibited mode");
  a_alt_drives_out: assert property (
      (alternation_period != 0) [*8] |-> alt_dev_oe)
    else $error("alternation not driven");
  a_alt_takes_in: assert property (
      (alternation_period == 0) [*8] |-> !alt_dev_oe)
    else $error("alternation pin driven");
  a_marker_after_fall: assert property (
      ($changed(first_dev_o) && first_dev_oe) ||
      ($changed(second_dev_o) && second_dev_oe) |-> quiet_q < 4'h9)
    else $error("marker moved off a line fall");
  a_alt_after_fall: assert property (
      $changed(alt_dev_o) && alt_dev_oe |-> quiet_q < 4'h9)
    else $error("alternation moved off a line fall");
  a_alt_held_clear: assert property (
      (!generator_reset_n && alternation_period != 0) [*8] |-> !alt_dev_o)
    else $error("alternation kept in reset");
  a_pump_clock_tied: assert property (pump_enable [*2] |->
      pump_clock_in == line_shift_clock ||
      pump_clock_in == $past(line_shift_clock))
    else $error("pump clock not following line clock");
  a_pump_clock_low: assert property (
      (!pump_enable) [*2] |-> !pump_clock_in)
    else $error("pump clock with pump off");
endmodule // lcd_common_scan_control_monitor

// ==== verif/lcd_common_scan_control_test.sv ====
// self-checking bench joining controller and common driver ends
`include "lcd_scan_map.svh"

module lcd_common_scan_control_test;
  import lcd_scan_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic sys_rst;
  logic [3:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [239:0][1:0] common_level;
  logic alternation, alt_internal, mode_valid, pump_on, pump_drive, dir;
  int failures = 0;
  int num_checks = 0;
  int n;
  // a, b, direction, exit stage, falls until exit
  int rows [6][5] = '{'{1, 1, 1, 239, 240}, '{1, 0, 1, 219, 200},
    '{0, 1, 1, 199, 160}, '{1, 1, 0, 0, 240}, '{1, 0, 0, 20, 200},
    '{0, 1, 0, 40, 160}};
  logic [4:0] periods [3] = '{5'h02, 5'h03, 5'h1F};

  always #4 clock = ~clock;

  lcd_scan_if link ();
  wire lsc = link.line_shift_clock;
  wire pin_a = link.marker_pin_first;
  wire pin_b = link.marker_pin_second;

  // short line halves keep the 240-line scans brief
  lcd_scan_host #(.LINE_HALF(4)) lcd_scan_host_i (
    .i_clock(clock), .i_sys_rst(sys_rst), .link(link.host),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  lcd_scan_device lcd_scan_device_i (
    .i_clock(clock), .i_sys_rst(sys_rst), .link(link.device),
    .o_common_level(common_level), .o_alternation(alternation),
    .o_alt_internal(alt_internal), .o_mode_valid(mode_valid),
    .o_pump_on(pump_on), .o_pump_drive(pump_drive));
  lcd_common_scan_control_monitor lcd_common_scan_control_monitor_i (
    .i_clock(clock), .i_sys_rst(sys_rst), .line_shift_clock(lsc),
    .pump_clock_in(link.pump_clock_in),
    .pump_enable(link.pump_enable),
    .alternation_period(link.alternation_period),
    .output_count_select_a(link.output_count_select_a),
    .output_count_select_b(link.output_count_select_b),
    .shift_direction_select(link.shift_direction_select),
    .generator_reset_n(link.generator_reset_n),
    .first_dev_o(link.first_dev_o),
    .first_dev_oe(link.first_dev_oe),
    .second_dev_o(link.second_dev_o),
    .second_dev_oe(link.second_dev_oe),
    .alt_dev_o(link.alt_dev_o),
    .alt_dev_oe(link.alt_dev_oe));

  // ****************************************
  // bus cycles and comparison
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    awaddr <= a[3:0];
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a[3:0];
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // falls between alternation changes
  task automatic alt_gap();
    logic a;
    a = alternation;
    n = 0;
    do begin
      @(negedge lsc);
      n++;
    end while (alternation === a);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // sequence of tests
  // ****************************************
  initial begin
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0000_0000;
    sys_rst = 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    axi_rd(`REG_CTRL);
    check("ctrl reset", `CTRL_RESET, d);
    axi_rd(`REG_CFG);
    check("cfg reset", `CFG_RESET, d);
    axi_rd(8'h0C);
    check("unmapped read", {30'h0, `RESP_SLVERR}, {d[29:0], r});
    axi_wr(8'h0C, 32'h0000_0001);
    check("unmapped write", `RESP_SLVERR, r);
    // scan length per mode, external level high
    for (int i = 0; i < 6; i++) begin
      dir = rows[i][2] != 0;
      axi_wr(`REG_CTRL, 32'h0000_0000);
      axi_wr(`REG_CFG, {16'h0000, 8'hFF, 1'b0, rows[i][1] != 0,
        rows[i][0] != 0, 5'h00});
      axi_wr(`REG_CTRL, {28'h0000000, 1'b1, dir, 2'b01});
      do @(negedge lsc); while ((dir ? pin_b : pin_a) !== 1'b1);
      n = 0;
      do begin
        @(negedge lsc);
        n++;
      end while ((dir ? pin_a : pin_b) !== 1'b1);
      check("marker falls", rows[i][4], n);
      check("exit level", LVL_HIGH, common_level[rows[i][3]]);
      check("external mode", 0, alt_internal);
      repeat (2) @(negedge lsc);
    end
    // internal alternation periods
    axi_wr(`REG_CTRL, 32'h0000_0005);
    foreach (periods[k]) begin
      axi_wr(`REG_CFG, {16'h0000, 8'hFF, 3'b011, periods[k]});
      alt_gap();
      alt_gap();
      check("alternation lines", periods[k], n);
    end
    axi_wr(`REG_CTRL, 32'h0000_0015);
    repeat (40) @(negedge lsc);
    check("generator reset", 0, alternation);
    // pump on, then off
    axi_wr(`REG_CTRL, 32'h0000_0007);
    repeat (4) @(negedge lsc);
    n = 0;
    repeat (16) @(posedge clock) n += (pump_drive === 1'b1);
    check("pump drive cycles", 8, n);
    check("pump on", 1, pump_on);
    axi_wr(`REG_CTRL, 32'h0000_0005);
    repeat (8) @(posedge clock);
    check("pump off", 0, {pump_on, pump_drive});
    axi_wr(`REG_CFG, {16'h0000, 8'hFF, 8'h00});
    repeat (8) @(posedge clock);
    check("prohibited mode", 0, {mode_valid, link.first_dev_oe,
      link.second_dev_oe});
    axi_rd(`REG_STATUS);
    check("running", 1, d[`STAT_RUNNING]);
    complete_run();
  end

  // tests take about 13000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    complete_run();
  end
endmodule // lcd_common_scan_control_test
